// ===== hw/fmcsr_regs.sv
// fmcsr_regs: duty ceilings, main configuration and limit status registers
// of the fan monitor, reached over ahb-lite, with one interrupt output.
// assumes: limit conditions arrive as synchronous levels from the monitor.
//
// Functional notes
// - three read/write pwm duty ceilings, each resetting to 0xFF
// - after lock, duty ceiling writes are ignored
// - run bit (bit 0, reset 1): programmed limits when set, defaults else
// - clearing run bit keeps every programmed limit value
// - run bit read-only after lock; host programs limits before run
// - lock bit 1 writable once; locks lockable fields until power cycle
// - ready bit 2 read-only, set once power-up completes
// - bit 3 drives all fans to full speed, never locked
// - bit 4 stores the lockable power reporting indicator
// - bit 5 holds pwm high for whole spin-up timeout
// - bit 6 lockable, enables the bus timeout feature
// - bit 7 lockable, selects 5 V supply scale, else 3.3 V
// - status bits 0-2 flag 2.5 V, core, supply voltage violations
// - status bit 3 flags 5 V, or alarm timer when pin is alarm
// - status bits 4-6 flag remote 1, local, remote 2 temperatures
// - status bit 7 is the OR of second status register bits
// - second status holds 12 V, overtemp, fan, and diode fault flags
`timescale 1ns/1ps
module fmcsr_regs #(
  parameter logic [7:0] CEIL_DEFAULT = fmcsr_pkg::CEIL_DEFAULT
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // monitor conditions
  input wire logic power_up_done,
  input wire logic v25_cond,
  input wire logic core_voltage_cond,
  input wire logic supply_cond,
  input wire logic v5_cond,
  input wire logic thermal_alarm_pin,
  input wire logic alarm_timer_cond,
  input wire logic remote_one_temp_cond,
  input wire logic local_temp_cond,
  input wire logic remote_two_temp_cond,
  input wire logic [7:0] second_status_cond,
  // control to fan and measurement logic
  output logic [7:0] pwm1_ceiling_eff,
  output logic [7:0] pwm2_ceiling_eff,
  output logic [7:0] pwm3_ceiling_eff,
  output logic monitor_run_enable,
  output logic all_fans_max_drive,
  output logic power_report_indicator,
  output logic spinup_pulse_bypass,
  output logic bus_timeout_control,
  output logic supply_5v_scale,
  // interrupt
  output logic irq
);
  logic acc_rd;
  logic acc_wr;
  logic [fmcsr_pkg::IDX_BITS-1:0] acc_idx;
  logic [7:0] wdata;

  logic [7:0] ceiling [3];
  logic [7:0] cfg;
  logic locked;
  logic ready;

  logic [7:0] st1_cond;
  logic [6:0] st1_flags;
  logic [7:0] st2_flags;
  logic st1_new;
  logic st2_new;
  logic [7:0] status1;

  logic [fmcsr_pkg::IRQ_BITS-1:0] irq_status;
  logic [fmcsr_pkg::IRQ_BITS-1:0] irq_mask;
  logic [fmcsr_pkg::IRQ_BITS-1:0] irq_event;

  logic [7:0] next_rdata;

  // decoded strobes, valid in the wait cycle of a transfer
  logic wr_cfg;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic rd_status1;
  logic rd_status2;

  assign wdata = hwdata[7:0];
  assign wr_cfg = acc_wr && (acc_idx == fmcsr_pkg::IDX_CONFIG);
  assign wr_irq_status = acc_wr && (acc_idx == fmcsr_pkg::IDX_IRQ_STATUS);
  assign wr_irq_mask = acc_wr && (acc_idx == fmcsr_pkg::IDX_IRQ_MASK);
  assign rd_status1 = acc_rd && (acc_idx == fmcsr_pkg::IDX_STATUS1);
  assign rd_status2 = acc_rd && (acc_idx == fmcsr_pkg::IDX_STATUS2);

  // a flop like every other output; the slave never answers anything else
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= fmcsr_pkg::HRESP_OKAY;
    end else begin
      hresp <= fmcsr_pkg::HRESP_OKAY;
    end
  end

  fmcsr_ahb_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .acc_rd(acc_rd),
    .acc_wr(acc_wr),
    .acc_idx(acc_idx)
  );

  // duty ceilings: stored values stay put whatever the run bit does
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_ceil
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ceiling[c] <= fmcsr_pkg::CEIL_RESET;
        end else if (acc_wr && !locked &&
                     acc_idx == fmcsr_pkg::IDX_CEIL1 + 8'(c)) begin
          ceiling[c] <= wdata;
        end
      end
    end
  endgenerate

  // lock is sticky; only the asynchronous power-on reset clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked <= 1'b0;
    end else if (wr_cfg && wdata[fmcsr_pkg::CFG_LOCK]) begin
      locked <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready <= 1'b0;
    end else if (power_up_done) begin
      ready <= 1'b1;
    end
  end

  // configuration fields other than lock and ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= fmcsr_pkg::CONFIG_RESET;
    end else if (wr_cfg) begin
      cfg[fmcsr_pkg::CFG_MAX_DRIVE] <= wdata[fmcsr_pkg::CFG_MAX_DRIVE];
      cfg[fmcsr_pkg::CFG_SPINUP_BYPASS] <=
        wdata[fmcsr_pkg::CFG_SPINUP_BYPASS];
      if (!locked) begin
        cfg[fmcsr_pkg::CFG_RUN] <= wdata[fmcsr_pkg::CFG_RUN];
        cfg[fmcsr_pkg::CFG_POWER_REPORT] <=
          wdata[fmcsr_pkg::CFG_POWER_REPORT];
        cfg[fmcsr_pkg::CFG_BUS_TIMEOUT] <=
          wdata[fmcsr_pkg::CFG_BUS_TIMEOUT];
        cfg[fmcsr_pkg::CFG_SUPPLY_5V] <=
          wdata[fmcsr_pkg::CFG_SUPPLY_5V];
      end
    end
  end

  // lockable control outputs, registered so they come straight from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_run_enable <= 1'b0;
      power_report_indicator <= 1'b0;
      bus_timeout_control <= 1'b0;
      supply_5v_scale <= 1'b0;
    end else begin
      monitor_run_enable <= cfg[fmcsr_pkg::CFG_RUN];
      power_report_indicator <= cfg[fmcsr_pkg::CFG_POWER_REPORT];
      bus_timeout_control <= cfg[fmcsr_pkg::CFG_BUS_TIMEOUT];
      supply_5v_scale <= cfg[fmcsr_pkg::CFG_SUPPLY_5V];
    end
  end

  // control outputs that stay writable after lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      all_fans_max_drive <= 1'b0;
      spinup_pulse_bypass <= 1'b0;
    end else begin
      all_fans_max_drive <= cfg[fmcsr_pkg::CFG_MAX_DRIVE];
      spinup_pulse_bypass <= cfg[fmcsr_pkg::CFG_SPINUP_BYPASS];
    end
  end

  // with run cleared the fan logic sees the defaults, not the stored values
  logic [7:0] ceiling_eff [3];

  generate
    for (c = 0; c < 3; c++) begin : g_eff
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ceiling_eff[c] <= CEIL_DEFAULT;
        end else if (cfg[fmcsr_pkg::CFG_RUN]) begin
          ceiling_eff[c] <= ceiling[c];
        end else begin
          ceiling_eff[c] <= CEIL_DEFAULT;
        end
      end
    end
  endgenerate

  assign pwm1_ceiling_eff = ceiling_eff[0];
  assign pwm2_ceiling_eff = ceiling_eff[1];
  assign pwm3_ceiling_eff = ceiling_eff[2];

  // first status conditions; bit 7 is a summary, not a flag of its own
  always_comb begin
    st1_cond = 8'h00;
    st1_cond[fmcsr_pkg::ST1_V25] = v25_cond;
    st1_cond[fmcsr_pkg::ST1_CORE] = core_voltage_cond;
    st1_cond[fmcsr_pkg::ST1_SUPPLY] = supply_cond;
    st1_cond[fmcsr_pkg::ST1_V5_TIMER] =
      thermal_alarm_pin ? alarm_timer_cond : v5_cond;
    st1_cond[fmcsr_pkg::ST1_REMOTE1] = remote_one_temp_cond;
    st1_cond[fmcsr_pkg::ST1_LOCAL] = local_temp_cond;
    st1_cond[fmcsr_pkg::ST1_REMOTE2] = remote_two_temp_cond;
  end

  fmcsr_flag_bank #(
    .WIDTH(7)
  ) u_status1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .cond(st1_cond[6:0]),
    .rd_clr(rd_status1),
    .flags(st1_flags),
    .new_event(st1_new)
  );

  fmcsr_flag_bank #(
    .WIDTH(8)
  ) u_status2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .cond(second_status_cond),
    .rd_clr(rd_status2),
    .flags(st2_flags),
    .new_event(st2_new)
  );

  assign status1 = {|st2_flags, st1_flags};

  // interrupt: sticky, write one to clear, a new event wins the clear
  assign irq_event = {st2_new, st1_new};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
    end else if (wr_irq_status) begin
      irq_status <= (irq_status & ~wdata[fmcsr_pkg::IRQ_BITS-1:0]) |
                    irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= fmcsr_pkg::IRQ_MASK_RESET;
    end else if (wr_irq_mask) begin
      irq_mask <= wdata[fmcsr_pkg::IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // read mux; unmapped indices read as zero
  always_comb begin
    next_rdata = 8'h00;
    case (acc_idx)
      fmcsr_pkg::IDX_CEIL1: next_rdata = ceiling[0];
      fmcsr_pkg::IDX_CEIL2: next_rdata = ceiling[1];
      fmcsr_pkg::IDX_CEIL3: next_rdata = ceiling[2];
      fmcsr_pkg::IDX_CONFIG: begin
        next_rdata = cfg;
        next_rdata[fmcsr_pkg::CFG_LOCK] = locked;
        next_rdata[fmcsr_pkg::CFG_READY] = ready;
      end
      fmcsr_pkg::IDX_STATUS1: next_rdata = status1;
      fmcsr_pkg::IDX_STATUS2: next_rdata = st2_flags;
      fmcsr_pkg::IDX_IRQ_STATUS: next_rdata = 8'(irq_status);
      fmcsr_pkg::IDX_IRQ_MASK: next_rdata = 8'(irq_mask);
      default: next_rdata = 8'h00;
    endcase
  end

  // read data is caught in the wait cycle and held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (acc_rd) begin
      hrdata <= {24'h000000, next_rdata};
    end
  end

  // hsize is accepted but only whole-word transfers are supported
  logic unused_hsize;
  assign unused_hsize = |hsize;
endmodule : fmcsr_regs

// ===== hw/fmcsr_pkg.sv
// fmcsr_pkg: register indices, field positions, reset values and bus codes
// for the fan monitor configuration and status register block.
// assumes: used by the register and ahb port design files, not the flag bank; nothing is imported.
package fmcsr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CEIL1 = 8'h38;
  localparam logic [7:0] IDX_CEIL2 = 8'h39;
  localparam logic [7:0] IDX_CEIL3 = 8'h3A;
  localparam logic [7:0] IDX_CONFIG = 8'h40;
  localparam logic [7:0] IDX_STATUS1 = 8'h41;
  localparam logic [7:0] IDX_STATUS2 = 8'h42;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
  // byte address is the index shifted by this many bits
  localparam int IDX_SHIFT = 2;
  localparam int IDX_BITS = 8;

  // main configuration fields
  localparam int CFG_RUN = 0;
  localparam int CFG_LOCK = 1;
  localparam int CFG_READY = 2;
  localparam int CFG_MAX_DRIVE = 3;
  localparam int CFG_POWER_REPORT = 4;
  localparam int CFG_SPINUP_BYPASS = 5;
  localparam int CFG_BUS_TIMEOUT = 6;
  localparam int CFG_SUPPLY_5V = 7;

  // first status register fields
  localparam int ST1_V25 = 0;
  localparam int ST1_CORE = 1;
  localparam int ST1_SUPPLY = 2;
  localparam int ST1_V5_TIMER = 3;
  localparam int ST1_REMOTE1 = 4;
  localparam int ST1_LOCAL = 5;
  localparam int ST1_REMOTE2 = 6;
  localparam int ST1_SUMMARY = 7;

  // interrupt status / mask fields
  localparam int IRQ_FIRST = 0;
  localparam int IRQ_SECOND = 1;
  localparam int IRQ_BITS = 2;

  // reset values
  localparam logic [7:0] CEIL_RESET = 8'hFF;
  localparam logic [7:0] CEIL_DEFAULT = 8'hFF;
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // ahb-lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage : fmcsr_pkg

// ===== hw/fmcsr_flag_bank.sv
// fmcsr_flag_bank: a row of sticky limit flags cleared by a status read.
// assumes: cond inputs are synchronous levels; rd_clr is a one-cycle pulse.
`timescale 1ns/1ps
module fmcsr_flag_bank #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // conditions and read
  input wire logic [WIDTH-1:0] cond,
  input wire logic rd_clr,
  // flags
  output logic [WIDTH-1:0] flags,
  output logic new_event
);
  logic [WIDTH-1:0] rise;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // set wins over the read clear; a held condition survives the read
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flags[i] <= 1'b0;
        end else if (cond[i]) begin
          flags[i] <= 1'b1;
        end else if (rd_clr) begin
          flags[i] <= 1'b0;
        end
      end
      assign rise[i] = cond[i] & ~flags[i];
    end
  endgenerate

  assign new_event = |rise;
endmodule : fmcsr_flag_bank

// ===== hw/fmcsr_ahb_port.sv
// fmcsr_ahb_port: ahb-lite slave front end with one wait state per transfer.
// assumes: single word transfers only; one slave, so hready is hreadyout.
`timescale 1ns/1ps
module fmcsr_ahb_port (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  // register side, valid in the wait cycle
  output logic acc_rd,
  output logic acc_wr,
  output logic [fmcsr_pkg::IDX_BITS-1:0] acc_idx
);
  logic pend;
  logic pend_wr;
  logic take;

  assign take = hsel & hready & (htrans == fmcsr_pkg::HTRANS_NONSEQ);

  // the wait state lets a write land before any following read samples
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      pend_wr <= 1'b0;
      acc_idx <= '0;
      hreadyout <= 1'b1;
    end else if (take) begin
      pend <= 1'b1;
      pend_wr <= hwrite;
      acc_idx <= haddr[fmcsr_pkg::IDX_SHIFT +: fmcsr_pkg::IDX_BITS];
      hreadyout <= 1'b0;
    end else begin
      pend <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  assign acc_rd = pend & ~pend_wr;
  assign acc_wr = pend & pend_wr;
endmodule : fmcsr_ahb_port

// ===== test/fmcsr_regs_assertions.sv
// fmcsr_regs_assertions: bus timing and control output checks.
// assumes: bound to fmcsr_regs; sees only its ports; one clock domain.
`timescale 1ns/1ps
module fmcsr_regs_assertions (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // controls
  input wire logic [7:0] pwm1_ceiling_eff,
  input wire logic monitor_run_enable,
  input wire logic all_fans_max_drive,
  input wire logic bus_timeout_control,
  input wire logic supply_5v_scale
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic taken;
  logic wr_t;
  assign taken = hsel && hready && htrans == fmcsr_pkg::HTRANS_NONSEQ;
  assign wr_t = taken && hwrite;
  chk_resp_always_okay: assert property (hresp == fmcsr_pkg::HRESP_OKAY)
    else $error("hresp not okay");
  chk_one_wait_state: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  chk_idle_stays_ready: assert property (hreadyout && !taken |=> hreadyout)
    else $error("hreadyout dropped without a transfer");
  chk_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits not zero");
  chk_stopped_uses_default: assert property (
    !monitor_run_enable |-> pwm1_ceiling_eff == fmcsr_pkg::CEIL_DEFAULT)
    else $error("ceiling not default while stopped");
  // a write reaches a control output three edges after its address phase
  chk_ceiling_needs_write: assert property (
    $changed(pwm1_ceiling_eff) |-> $past(wr_t, 3))
    else $error("ceiling moved without a write");
  chk_max_drive_write: assert property (
    $changed(all_fans_max_drive) |-> $past(wr_t, 3))
    else $error("full speed moved without a write");
  chk_timeout_by_write: assert property (
    $changed(bus_timeout_control) |-> $past(wr_t, 3))
    else $error("bus timeout moved without a write");
  chk_supply_by_write: assert property (
    $changed(supply_5v_scale) |-> $past(wr_t, 3))
    else $error("supply scale moved without a write");
endmodule : fmcsr_regs_assertions

bind fmcsr_regs fmcsr_regs_assertions fmcsr_regs_assertions_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .pwm1_ceiling_eff(pwm1_ceiling_eff),
  .monitor_run_enable(monitor_run_enable),
  .all_fans_max_drive(all_fans_max_drive),
  .bus_timeout_control(bus_timeout_control),
  .supply_5v_scale(supply_5v_scale)
);

// ===== test/fmcsr_ahb_master.sv
// fmcsr_ahb_master: behavioural ahb-lite host, single word transfers.
// assumes: one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module fmcsr_ahb_master (
  // clock
  input wire logic hclk,
  // ahb-lite master
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h0,
  output logic [1:0] htrans = 2'h0,
  output logic [2:0] hsize = 3'h2,
  output logic hwrite = 1'b0,
  output logic [31:0] hwdata = 32'h0,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [7:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= fmcsr_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    // stale address is inverted so nothing relies on it after the phase
    hsel <= 1'b0;
    haddr <= ~haddr;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata[7:0];
  endtask : xfer
endmodule : fmcsr_ahb_master

// ===== test/fmcsr_regs_tb.sv
// fmcsr_regs_tb: directed scenarios for the fan monitor register block.
// assumes: package and design compiled first; host model drives the bus.
`timescale 1ns/1ps
`define CK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module fmcsr_regs_tb;
  logic hclk = 1'b0, hresetn = 1'b0, power_up_done = 1'b0;
  logic v25_cond = 0, core_voltage_cond = 0, supply_cond = 0, v5_cond = 0;
  logic remote_one_temp_cond = 0, local_temp_cond = 0;
  logic remote_two_temp_cond = 0, thermal_alarm_pin = 0;
  logic alarm_timer_cond = 0;
  logic [7:0] second_status_cond = 8'h00;
  logic hsel, hwrite, hreadyout, hresp, irq;
  logic run, fmax, prep, spin, btmo, s5v;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ce1, ce2, ce3, rv;
  int bad_count = 0, total_checks = 0, cyc = 0;
  always #5 hclk = ~hclk;
  fmcsr_ahb_master fmcsr_ahb_master_inst (.hclk(hclk), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  fmcsr_regs fmcsr_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwrite(hwrite),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .power_up_done(power_up_done),
    .v25_cond(v25_cond), .core_voltage_cond(core_voltage_cond),
    .supply_cond(supply_cond), .v5_cond(v5_cond),
    .thermal_alarm_pin(thermal_alarm_pin),
    .alarm_timer_cond(alarm_timer_cond),
    .remote_one_temp_cond(remote_one_temp_cond),
    .local_temp_cond(local_temp_cond),
    .remote_two_temp_cond(remote_two_temp_cond),
    .second_status_cond(second_status_cond), .pwm1_ceiling_eff(ce1),
    .pwm2_ceiling_eff(ce2), .pwm3_ceiling_eff(ce3),
    .monitor_run_enable(run), .all_fans_max_drive(fmax),
    .power_report_indicator(prep), .spinup_pulse_bypass(spin),
    .bus_timeout_control(btmo), .supply_5v_scale(s5v), .irq(irq));
  task give_verdict;
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // a hung handshake would otherwise stall the run forever
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      give_verdict();
    end
  end
  task wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task wr(input logic [7:0] i, input logic [7:0] d);
    fmcsr_ahb_master_inst.xfer(1'b1, i, d, rv);
  endtask : wr
  task rdc(input logic [7:0] i, input logic [7:0] e);
    fmcsr_ahb_master_inst.xfer(1'b0, i, 8'h00, rv);
    `CK($sformatf("reg %h", i), e, rv)
  endtask : rdc
  task t_reset;
    rdc(fmcsr_pkg::IDX_CEIL1, 8'hFF);
    rdc(fmcsr_pkg::IDX_CEIL3, 8'hFF);
    rdc(fmcsr_pkg::IDX_CONFIG, 8'h01);
    rdc(fmcsr_pkg::IDX_STATUS1, 8'h00);
    rdc(fmcsr_pkg::IDX_IRQ_MASK, 8'h00);
    rdc(8'h7F, 8'h00);
    power_up_done <= 1'b1;
    wt(2);
    power_up_done <= 1'b0;
    rdc(fmcsr_pkg::IDX_CONFIG, 8'h05);
  endtask : t_reset
  task t_ceil;
    wr(fmcsr_pkg::IDX_CEIL1, 8'h12);
    wr(fmcsr_pkg::IDX_CEIL2, 8'h34);
    wr(fmcsr_pkg::IDX_CEIL3, 8'hA5);
    wt(2);
    `CK("eff1", 8'h12, ce1)
    `CK("eff3", 8'hA5, ce3)
    wr(fmcsr_pkg::IDX_CONFIG, 8'h00);
    wt(2);
    `CK("eff2", 8'hFF, ce2)
    rdc(fmcsr_pkg::IDX_CEIL2, 8'h34);
    wr(fmcsr_pkg::IDX_CONFIG, 8'h01);
    wt(2);
    `CK("eff2", 8'h34, ce2)
  endtask : t_ceil
  task t_cfg;
    wr(fmcsr_pkg::IDX_CONFIG, 8'hF9);
    wt(2);
    `CK("fmax", 1'b1, fmax)
    `CK("prep", 1'b1, prep)
    `CK("spin", 1'b1, spin)
    `CK("btmo", 1'b1, btmo)
    `CK("s5v", 1'b1, s5v)
    rdc(fmcsr_pkg::IDX_CONFIG, 8'hFD);
    wr(fmcsr_pkg::IDX_CONFIG, 8'h01);
    wt(2);
    `CK("s5v", 1'b0, s5v)
  endtask : t_cfg
  task t_status;
    {remote_two_temp_cond, local_temp_cond, remote_one_temp_cond, v5_cond,
      supply_cond, core_voltage_cond, v25_cond} <= 7'h7F;
    wt(2);
    {remote_two_temp_cond, local_temp_cond, remote_one_temp_cond, v5_cond,
      supply_cond, core_voltage_cond} <= 6'h00;
    wt(2);
    rdc(fmcsr_pkg::IDX_STATUS1, 8'h7F);
    rdc(fmcsr_pkg::IDX_STATUS1, 8'h01);
    v25_cond <= 1'b0;
    rdc(fmcsr_pkg::IDX_STATUS1, 8'h01);
    thermal_alarm_pin <= 1'b1;
    v5_cond <= 1'b1;
    wt(2);
    v5_cond <= 1'b0;
    rdc(fmcsr_pkg::IDX_STATUS1, 8'h00);
    alarm_timer_cond <= 1'b1;
    wt(2);
    alarm_timer_cond <= 1'b0;
    rdc(fmcsr_pkg::IDX_STATUS1, 8'h08);
    second_status_cond <= 8'h04;
    wt(2);
    second_status_cond <= 8'h00;
    rdc(fmcsr_pkg::IDX_STATUS1, 8'h80);
    rdc(fmcsr_pkg::IDX_STATUS2, 8'h04);
    rdc(fmcsr_pkg::IDX_STATUS1, 8'h00);
  endtask : t_status
  task t_irq;
    `CK("irq", 1'b0, irq)
    rdc(fmcsr_pkg::IDX_IRQ_STATUS, 8'h03);
    wr(fmcsr_pkg::IDX_IRQ_MASK, 8'h02);
    wt(2);
    `CK("irq", 1'b1, irq)
    wr(fmcsr_pkg::IDX_IRQ_STATUS, 8'h02);
    wt(2);
    `CK("irq", 1'b0, irq)
    rdc(fmcsr_pkg::IDX_IRQ_STATUS, 8'h01);
    second_status_cond <= 8'h40;
    wt(1);
    second_status_cond <= 8'h00;
    wt(2);
    `CK("irq", 1'b1, irq)
    rdc(fmcsr_pkg::IDX_STATUS2, 8'h40);
  endtask : t_irq
  task t_lock;
    wr(fmcsr_pkg::IDX_CONFIG, 8'h43);
    wr(fmcsr_pkg::IDX_CEIL1, 8'h55);
    rdc(fmcsr_pkg::IDX_CEIL1, 8'h12);
    wr(fmcsr_pkg::IDX_CONFIG, 8'h08);
    wt(2);
    `CK("run", 1'b1, run)
    `CK("fmax", 1'b1, fmax)
    `CK("eff1", 8'h12, ce1)
    rdc(fmcsr_pkg::IDX_CONFIG, 8'h4F);
    hresetn <= 1'b0;
    wt(2);
    hresetn <= 1'b1;
    rdc(fmcsr_pkg::IDX_CONFIG, 8'h01);
    wr(fmcsr_pkg::IDX_CEIL1, 8'h66);
    rdc(fmcsr_pkg::IDX_CEIL1, 8'h66);
  endtask : t_lock
  initial begin
    wt(10);
    hresetn <= 1'b1;
    t_reset();
    t_ceil();
    t_cfg();
    t_status();
    t_irq();
    t_lock();
    give_verdict();
  end
endmodule : fmcsr_regs_tb
